// ### design/adc_sequencer_control.sv
// converter control: registers over AXI4-Lite, clock divider, SAR sequencing, pin override
// What this block does
// - write starts conversion, 16-17 divided clocks
// - continuous mode overwrites result, repeats until cleared
// - single mode converts once per write
// - selected pin forced input, reads zero
// - full scale FF, zero scale 00, linear
// - flag set at end, cleared by result read
// - with irq enabled flag never sets, reads zero
// - reset clears flag, irq enable, continuous
// - irq at end, cleared by result read or control write
// - 5-bit select, unused codes give unknown result
// - all-ones select powers converter down
// - 8-bit result loaded every conversion end
// - 3-bit prescaler divides by 1,2,4,8,16
// - clock select 1 bus, 0 crystal, reset crystal
// - stop aborts conversion, resumes after stop
// - wait mode keeps converting, irq wakes
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
module adc_sequencer_control
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // clock source and system modes
    input wire logic crystal_clock,
    input wire logic stop_mode,
    // analog multiplexer and comparator
    output logic [4:0] channel_select_field,
    output logic [7:0] ext_channel_enable,
    output logic high_reference_select,
    output logic low_reference_select,
    output logic analog_power_down,
    output logic sample_hold,
    output logic [7:0] trial_code,
    input wire logic comparator_above,
    // shared port pins
    input wire logic [7:0] port_data,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] port_read_data,
    // interrupt request
    output logic conv_irq
);
    state_t cur;
    state_t next_cur;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;
    logic ctrl_write;
    logic result_read;
    logic src_tick;
    logic adc_tick;
    logic [3:0] div_limit;
    logic start_req;
    logic [7:0] new_sar;
    logic [7:0] agree;
    logic [7:0] wbyte;
    logic [7:0] pin_sel;

    assign s_axi_awready = !cur.aw_held && !cur.bvalid;
    assign s_axi_wready = !cur.w_held && !cur.bvalid;
    assign s_axi_arready = !cur.rvalid;
    assign s_axi_bvalid = cur.bvalid;
    assign s_axi_bresp = cur.bresp;
    assign s_axi_rvalid = cur.rvalid;
    assign s_axi_rresp = cur.rresp;
    assign s_axi_rdata = cur.rdata;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    assign channel_select_field = cur.channel;
    assign high_reference_select = (cur.channel == `CHAN_REF_HIGH);
    assign low_reference_select = (cur.channel == `CHAN_REF_LOW);
    assign analog_power_down = (cur.channel == `CHAN_POWER_OFF) || stop_mode;
    assign sample_hold = (cur.state == ST_CONV) && (cur.tick_count < `SAMPLE_TICKS);
    // trial code spans 00 to FF
    assign trial_code = cur.sar | cur.mask;
    // request stays live in wait mode
    assign conv_irq = cur.irq_req && cur.irq_enable;

    // per-pin override of the port logic
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            assign pin_sel[gi] = (cur.channel == 5'(gi));
            assign ext_channel_enable[gi] = pin_sel[gi];
            assign pin_out[gi] = pin_sel[gi] ? 1'b0 : port_data[gi];
            assign pin_oe[gi] = pin_sel[gi] ? 1'b0 : port_dir[gi];
            assign port_read_data[gi] = pin_sel[gi] ? 1'b0 :
                (port_dir[gi] ? port_data[gi] : cur.pin_filt[gi]);
        end
    endgenerate

    always_comb begin
        case (cur.prescale)
            3'h0: div_limit = 4'h0;
            3'h1: div_limit = 4'h1;
            3'h2: div_limit = 4'h3;
            3'h3: div_limit = 4'h7;
            default: div_limit = 4'hF;
        endcase
    end

    always_comb begin
        next_cur = cur;
        // strobe is taken with the data, the master may drop it after the handshake
        wbyte = cur.w_strb ? cur.w_data : 8'h00;
        do_write = cur.aw_held && cur.w_held && !cur.bvalid;
        ctrl_write = do_write && (cur.aw_addr == `OFS_STATUS_CONTROL) && cur.w_strb;
        result_read = ar_take && (s_axi_araddr[3:0] == `OFS_RESULT);
        start_req = 1'b0;
        new_sar = cur.sar;

        // crystal is foreign: edge counts once second and third stages agree
        next_cur.xtal_sync = {cur.xtal_sync[1:0], crystal_clock};
        if (cur.xtal_sync[1] == cur.xtal_sync[2]) begin
            next_cur.xtal_filt = cur.xtal_sync[2];
        end
        next_cur.pin_s1 = pin_in;
        next_cur.pin_s2 = cur.pin_s1;
        next_cur.pin_s3 = cur.pin_s2;
        agree = ~(cur.pin_s2 ^ cur.pin_s3);
        next_cur.pin_filt = (agree & cur.pin_s3) | (~agree & cur.pin_filt);

        // bus clock when set, crystal otherwise
        src_tick = cur.clk_sel ? 1'b1 :
            (cur.xtal_sync[1] && cur.xtal_sync[2] && !cur.xtal_filt);
        // free-running divider, so the first tick lands anywhere: 16 or 17 clocks
        adc_tick = src_tick && (cur.div_count >= div_limit);
        if (src_tick) begin
            next_cur.div_count = adc_tick ? 4'h0 : cur.div_count + 4'h1;
        end

        // axi capture
        if (aw_take) begin
            next_cur.aw_held = 1'b1;
            next_cur.aw_addr = s_axi_awaddr[3:0];
        end
        if (w_take) begin
            next_cur.w_held = 1'b1;
            next_cur.w_data = s_axi_wdata[7:0];
            next_cur.w_strb = s_axi_wstrb[0];
        end
        if (cur.bvalid && s_axi_bready) begin
            next_cur.bvalid = 1'b0;
        end
        if (do_write) begin
            next_cur.aw_held = 1'b0;
            next_cur.w_held = 1'b0;
            next_cur.bvalid = 1'b1;
            next_cur.bresp = `RESP_OKAY;
            case (cur.aw_addr)
                `OFS_STATUS_CONTROL: begin
                    if (cur.w_strb) begin
                        // flag position of the write is ignored
                        next_cur.irq_enable = wbyte[`BIT_IRQ_ENABLE];
                        next_cur.continuous = wbyte[`BIT_CONTINUOUS];
                        next_cur.channel = wbyte[`CHAN_MSB:0];
                        start_req = (wbyte[`CHAN_MSB:0] != `CHAN_POWER_OFF);
                    end
                end
                `OFS_CLOCK_CONFIG: begin
                    if (cur.w_strb) begin
                        next_cur.prescale = wbyte[`PRESC_MSB:`PRESC_LSB];
                        next_cur.clk_sel = wbyte[`BIT_INPUT_CLK_SEL];
                    end
                end
                `OFS_RESULT: next_cur.bresp = `RESP_OKAY;
                default: next_cur.bresp = `RESP_SLVERR;
            endcase
        end
        // write to control drops the request
        if (ctrl_write) begin
            next_cur.irq_req = 1'b0;
        end

        if (cur.rvalid && s_axi_rready) begin
            next_cur.rvalid = 1'b0;
        end
        if (ar_take) begin
            next_cur.rvalid = 1'b1;
            next_cur.rresp = `RESP_OKAY;
            next_cur.rdata = 32'h0000_0000;
            case (s_axi_araddr[3:0])
                `OFS_STATUS_CONTROL: begin
                    // flag reads zero while irq enabled
                    next_cur.rdata[`BIT_DONE_FLAG] = cur.done_flag && !cur.irq_enable;
                    next_cur.rdata[`BIT_IRQ_ENABLE] = cur.irq_enable;
                    next_cur.rdata[`BIT_CONTINUOUS] = cur.continuous;
                    next_cur.rdata[`CHAN_MSB:0] = cur.channel;
                end
                `OFS_RESULT: next_cur.rdata[7:0] = cur.result;
                `OFS_CLOCK_CONFIG: begin
                    next_cur.rdata[`PRESC_MSB:`PRESC_LSB] = cur.prescale;
                    next_cur.rdata[`BIT_INPUT_CLK_SEL] = cur.clk_sel;
                end
                default: next_cur.rresp = `RESP_SLVERR;
            endcase
        end
        // result read clears flag and request
        if (result_read) begin
            next_cur.done_flag = 1'b0;
            next_cur.irq_req = 1'b0;
        end

        case (cur.state)
            ST_IDLE: begin
                if (cur.resume && !stop_mode) begin
                    start_req = (cur.channel != `CHAN_POWER_OFF);
                    next_cur.resume = 1'b0;
                end
            end
            ST_CONV: begin
                if (stop_mode) begin
                    next_cur.state = ST_IDLE;
                    next_cur.resume = 1'b1;
                    next_cur.mask = 8'h00;
                end else if (adc_tick) begin
                    next_cur.tick_count = cur.tick_count + 5'h01;
                    if (cur.tick_count == `SAMPLE_TICKS - 5'h01) begin
                        next_cur.mask = 8'h80;
                    end
                    if (cur.mask != 8'h00) begin
                        new_sar = comparator_above ? (cur.sar | cur.mask) : cur.sar;
                        next_cur.sar = new_sar;
                        next_cur.mask = cur.mask >> 1;
                    end
                    // seventeenth tick ends it, the first is partial
                    if (cur.tick_count == `LAST_TICK) begin
                        next_cur.result = new_sar;
                        // set wins over a same-cycle read
                        if (!cur.irq_enable) begin
                            next_cur.done_flag = 1'b1;
                        end
                        if (cur.irq_enable) begin
                            next_cur.irq_req = 1'b1;
                        end
                        next_cur.state = ST_IDLE;
                        if (cur.continuous && cur.channel != `CHAN_POWER_OFF) begin
                            start_req = 1'b1;
                        end
                    end
                end
            end
            default: next_cur.state = ST_IDLE;
        endcase

        // a control write restarts with new settings
        if (ctrl_write) begin
            next_cur.state = ST_IDLE;
            next_cur.resume = 1'b0;
            if (stop_mode) begin
                next_cur.resume = start_req;
                start_req = 1'b0;
            end
        end
        if (start_req) begin
            next_cur.state = ST_CONV;
            next_cur.tick_count = 5'h00;
            next_cur.sar = 8'h00;
            next_cur.mask = 8'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // reset clears flag, enable and continuous
            cur <= '0;
            cur.state <= ST_IDLE;
            cur.channel <= `CHAN_RESET;
        end else begin
            cur <= next_cur;
        end
    end
endmodule
`default_nettype wire

// ### inc/adc_seq_params.svh
// offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
`define OFS_STATUS_CONTROL 4'h0
`define OFS_RESULT 4'h4
`define OFS_CLOCK_CONFIG 4'h8
`define BIT_DONE_FLAG 7
`define BIT_IRQ_ENABLE 6
`define BIT_CONTINUOUS 5
`define CHAN_MSB 4
`define PRESC_MSB 7
`define PRESC_LSB 5
`define BIT_INPUT_CLK_SEL 4
`define CHAN_POWER_OFF 5'h1F
`define CHAN_REF_HIGH 5'h1D
`define CHAN_REF_LOW 5'h1E
`define CHAN_RESET 5'h1F
`define CONV_TICKS_MIN 16
`define CONV_TICKS_MAX 17
`define SAMPLE_TICKS 5'h08
`define LAST_TICK 5'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### inc/adc_seq_pkg.sv
// types of the converter control block
package adc_seq_pkg;
    `include "adc_seq_params.svh"
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } conv_state_t;
    typedef struct packed {
        conv_state_t state;
        logic done_flag;
        logic irq_enable;
        logic continuous;
        logic [4:0] channel;
        logic [2:0] prescale;
        logic clk_sel;
        logic irq_req;
        logic resume;
        logic [7:0] result;
        logic [7:0] sar;
        logic [7:0] mask;
        logic [4:0] tick_count;
        logic [3:0] div_count;
        logic [2:0] xtal_sync;
        logic xtal_filt;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [7:0] pin_s3;
        logic [7:0] pin_filt;
        logic aw_held;
        logic [3:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_t;
endpackage

// ### tb/adc_seq_props.sv
// port assertions of the converter control, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module adc_seq_props (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // watched signals
    input wire logic s_axi_bvalid,
    input wire logic stop_mode,
    input wire logic [4:0] channel_select_field,
    input wire logic [7:0] ext_channel_enable,
    input wire logic high_reference_select,
    input wire logic low_reference_select,
    input wire logic analog_power_down,
    input wire logic sample_hold,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] port_read_data,
    input wire logic conv_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    property p_pin_oe;
        disable iff (!aresetn) pin_oe == (port_dir & ~ext_channel_enable);
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("selected pin still driven");
    property p_pin_zero;
        disable iff (!aresetn) ((pin_out | port_read_data) & ext_channel_enable) == 8'h00;
    endproperty
    a_pin_zero: assert property (p_pin_zero) else $error("selected pin not zero");
    property p_one_hot;
        disable iff (!aresetn) (channel_select_field < 5'h08)
            |-> ext_channel_enable == (8'h01 << channel_select_field[2:0]);
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("wrong external channel");
    property p_ref_high;
        disable iff (!aresetn) high_reference_select == (channel_select_field == 5'h1D);
    endproperty
    a_ref_high: assert property (p_ref_high) else $error("high reference routing");
    property p_ref_low;
        disable iff (!aresetn) low_reference_select == (channel_select_field == 5'h1E);
    endproperty
    a_ref_low: assert property (p_ref_low) else $error("low reference routing");
    property p_power;
        disable iff (!aresetn) (channel_select_field == 5'h1F || stop_mode) |-> analog_power_down;
    endproperty
    a_power: assert property (p_power) else $error("converter not powered down");
    property p_stop_abort;
        disable iff (!aresetn) stop_mode |=> !sample_hold && !$rose(conv_irq);
    endproperty
    a_stop_abort: assert property (p_stop_abort) else $error("converting in stop");
    // reset itself is the antecedent, so this one is never disabled
    property p_reset;
        !aresetn |=> channel_select_field == 5'h1F && !conv_irq && !s_axi_bvalid;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    c_irq: cover property (disable iff (!aresetn) $rose(conv_irq));
    c_stop: cover property (disable iff (!aresetn) stop_mode && sample_hold);
    c_ref: cover property (disable iff (!aresetn) high_reference_select && sample_hold);
endmodule
bind adc_sequencer_control adc_seq_props adc_seq_props_i (.*);
`default_nettype wire

// ### tb/analog_model.sv
// far side: analog multiplexer and comparator against the trial code
`timescale 1ns/1ps
`default_nettype none
module analog_model (
    // channel choice and trial value
    input wire logic [7:0] ext_channel_enable,
    input wire logic high_reference_select,
    input wire logic analog_power_down,
    input wire logic [7:0] trial_code,
    // levels on the external channels
    input wire logic [7:0][7:0] vin,
    // decision
    output logic comparator_above
);
    logic [7:0] level;
    always_comb begin
        level = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (ext_channel_enable[k]) begin
                level = vin[k];
            end
        end
        if (high_reference_select) begin
            level = 8'hFF;
        end
        // ideal model settles at once after power-up
        comparator_above = analog_power_down ? ~trial_code[0] : (level >= trial_code);
    end
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench of the converter control
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adc_seq_pkg::*;
    logic aclk = 0, aresetn = 0, crystal_clock = 0, stop_mode = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, high_reference_select, low_reference_select, analog_power_down;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [4:0] channel_select_field;
    logic [7:0] ext_channel_enable, trial_code, pin_out, pin_oe, port_read_data;
    logic sample_hold, comparator_above, conv_irq;
    logic [7:0] port_data = 8'hFF, port_dir = 8'h0F, pin_in = 8'h5A;
    logic [7:0][7:0] vin = {8'hF0, 8'h3C, 8'h99, 8'hA5, 8'h11, 8'h80, 8'h01, 8'h5A};
    int n_errors = 0, tests_run = 0;
    adc_sequencer_control adc_sequencer_control_i (.*);
    analog_model analog_model_i (.*);
    always #25 aclk = ~aclk;
    // crystal deliberately slower and unrelated to the bus clock
    always #110 crystal_clock = ~crystal_clock;
    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        check("bresp", s_axi_bresp, (a[3:0] inside {4'h0, 4'h4, 4'h8}) ? 2'h0 : 2'h2);
        s_axi_bready <= 1'b0;
        // idle edge so a following call never re-raises bready in this step
        @(posedge aclk);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic wait_irq(output int n);
        n = 0;
        while (conv_irq !== 1'b1 && n < 2000) begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic t_reset_xtal();
        logic [31:0] d;
        logic [1:0] r;
        int k;
        rd(32'h0, d, r);
        check("ctrl_reset", d, 32'h1F);
        rd(32'h8, d, r);
        check("clk_reset", d, 32'h0);
        rd(32'hC, d, r);
        check("unmapped_resp", r, 2'h2);
        wr(32'hC, 32'h0);
        wr(32'h0, 32'h02);
        k = 0;
        d = 0;
        while (d[7] !== 1'b1 && k < 100) begin
            rd(32'h0, d, r);
            k++;
        end
        check("xtal_flag", d, 32'h82);
        check("pin_oe", pin_oe, 8'h0B);
        check("pin_out", pin_out, 8'hFB);
        check("port_read", port_read_data, 8'h5B);
        rd(32'h4, d, r);
        check("xtal_result", d, 32'h80);
        rd(32'h0, d, r);
        check("flag_cleared", d, 32'h02);
        $display("test reset_xtal done");
    endtask
    task automatic t_prescale();
        logic [31:0] d;
        logic [1:0] r;
        int n, p, dv;
        logic [4:0] chs[8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h07, 5'h1D, 5'h1E};
        int pc[8] = '{0, 1, 2, 3, 4, 7, 0, 0};
        for (int i = 0; i < 8; i++) begin
            p = pc[i];
            dv = (p > 3) ? 16 : (1 << p);
            wr(32'h8, 32'h10 | (p << 5));
            wr(32'h0, 32'h40 | chs[i]);
            wait_irq(n);
            check("conv_time", n >= 16 * dv - 2 && n <= 17 * dv + 3, 1'b1);
            rd(32'h0, d, r);
            check("irq_ctrl", d, 32'h40 | chs[i]);
            rd(32'h4, d, r);
            check("result", d, chs[i] < 8 ? vin[chs[i]] : (chs[i] == 5'h1D ? 8'hFF : 8'h00));
            check("irq_read_clear", conv_irq, 1'b0);
        end
        $display("test prescale done");
    endtask
    task automatic t_cont();
        logic [31:0] d;
        logic [1:0] r;
        wr(32'h8, 32'h10);
        wr(32'h0, 32'h25);
        repeat (60) @(posedge aclk);
        rd(32'h0, d, r);
        check("cont_flag", d, 32'hA5);
        vin[5] <= 8'hC3;
        repeat (60) @(posedge aclk);
        rd(32'h4, d, r);
        check("cont_overwrite", d, 32'hC3);
        wr(32'h0, 32'h05);
        repeat (60) @(posedge aclk);
        rd(32'h4, d, r);
        repeat (60) @(posedge aclk);
        rd(32'h0, d, r);
        check("single_once", d, 32'h05);
        $display("test cont done");
    endtask
    task automatic t_stop_restart();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        // bus clock over 16, near 1 MHz
        wr(32'h8, 32'h90);
        wr(32'h0, 32'h41);
        repeat (50) @(posedge aclk);
        stop_mode <= 1'b1;
        n = 0;
        repeat (300) begin
            @(posedge aclk);
            n += (conv_irq === 1'b1);
        end
        check("stop_irq", n, 0);
        stop_mode <= 1'b0;
        wait_irq(n);
        check("resume_time", n >= 254 && n <= 275, 1'b1);
        rd(32'h4, d, r);
        check("resume_result", d, 32'h01);
        wr(32'h0, 32'h42);
        repeat (100) @(posedge aclk);
        wr(32'h0, 32'h46);
        wait_irq(n);
        check("restart_time", n >= 254 && n <= 275, 1'b1);
        rd(32'h4, d, r);
        check("restart_result", d, 32'h3C);
        wr(32'h0, 32'h46);
        wait_irq(n);
        wr(32'h0, 32'h5F);
        check("irq_write_clear", conv_irq, 1'b0);
        $display("test stop_restart done");
    endtask
    initial begin
        repeat (30000) @(posedge aclk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_xtal();
        t_prescale();
        t_cont();
        t_stop_restart();
        report_and_stop();
    end
endmodule
`default_nettype wire
